/* tpg_pkg.sv */
`default_nettype none
package tpg_pkg;

  // ----------------------------------------------------------------
  // Port geometry and bus widths.
  // ----------------------------------------------------------------
  localparam int unsigned NPORT  = 3;
  localparam int unsigned PW     = 8;
  localparam int unsigned ADDR_W = 17;
  localparam int unsigned IDX_W  = 15;

  // ----------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_SEL_A = 15'h7f93;
  localparam logic [IDX_W-1:0] IDX_SEL_B = 15'h7f94;
  localparam logic [IDX_W-1:0] IDX_SEL_C = 15'h7f95;
  localparam logic [IDX_W-1:0] IDX_OUT_A = 15'h7f96;
  localparam logic [IDX_W-1:0] IDX_OUT_B = 15'h7f97;
  localparam logic [IDX_W-1:0] IDX_OUT_C = 15'h7f98;
  localparam logic [IDX_W-1:0] IDX_PIN_A = 15'h7f99;
  localparam logic [IDX_W-1:0] IDX_PIN_B = 15'h7f9a;
  localparam logic [IDX_W-1:0] IDX_PIN_C = 15'h7f9b;
  localparam logic [IDX_W-1:0] IDX_OE_A  = 15'h7f9c;
  localparam logic [IDX_W-1:0] IDX_OE_B  = 15'h7f9d;
  localparam logic [IDX_W-1:0] IDX_OE_C  = 15'h7f9e;

  // ----------------------------------------------------------------
  // Reset values and bus answers.
  // ----------------------------------------------------------------
  localparam logic [PW-1:0] OUT_RST     = 8'h00;
  localparam logic [PW-1:0] OE_RST      = 8'h00;
  localparam logic [PW-1:0] SEL_RST     = 8'h00;
  localparam logic [1:0]    RESP_OKAY   = 2'h0;
  localparam logic [1:0]    RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types.
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {KIND_OUT, KIND_PIN, KIND_OE, KIND_SEL} tpg_kind_type;

  typedef struct packed {
    logic         hit;
    tpg_kind_type kind;
    logic [1:0]   port;
  } tpg_dec_type;

  typedef struct packed {
    logic [PW-1:0] o;
    logic [PW-1:0] oe;
  } tpg_drive_type;

  // Maps a byte address onto register kind and port.
  function automatic tpg_dec_type tpg_decode(input logic [ADDR_W-1:0] addr);
    tpg_dec_type r;
    r = '{hit: 1'b1, kind: KIND_OUT, port: 2'h0};
    unique case (addr[ADDR_W-1:2])
      IDX_OUT_A: r = '{1'b1, KIND_OUT, 2'h0};
      IDX_OUT_B: r = '{1'b1, KIND_OUT, 2'h1};
      IDX_OUT_C: r = '{1'b1, KIND_OUT, 2'h2};
      IDX_PIN_A: r = '{1'b1, KIND_PIN, 2'h0};
      IDX_PIN_B: r = '{1'b1, KIND_PIN, 2'h1};
      IDX_PIN_C: r = '{1'b1, KIND_PIN, 2'h2};
      IDX_OE_A:  r = '{1'b1, KIND_OE, 2'h0};
      IDX_OE_B:  r = '{1'b1, KIND_OE, 2'h1};
      IDX_OE_C:  r = '{1'b1, KIND_OE, 2'h2};
      IDX_SEL_A: r = '{1'b1, KIND_SEL, 2'h0};
      IDX_SEL_B: r = '{1'b1, KIND_SEL, 2'h1};
      IDX_SEL_C: r = '{1'b1, KIND_SEL, 2'h2};
      default:   r.hit = 1'b0;
    endcase
    return r;
  endfunction : tpg_decode

endpackage : tpg_pkg
`default_nettype wire

/* tpg_sync.sv */
`default_nettype none
module tpg_sync #(
  parameter int unsigned W = 24
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Asynchronous levels in, settled levels out.
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  // The first stage feeds only the second stage.
  always_comb begin
    meta_d = d;
    q_d    = meta_q;
  end

  // Two flip-flops per bit, cleared by the synchronous reset.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= meta_d;
      q      <= q_d;
    end
  end

endmodule : tpg_sync
`default_nettype wire

/* tpg_gpio.sv */
// Behaviour
// RQ1 - Pin outputs its latch bit when drive enabled and alternate function unselected.
// RQ2 - Latch writes are stored while drive is off, but the pin stays undriven.
// RQ3 - Pin-sample read returns live pin levels in either I/O or alternate use.
// RQ4 - Drive-enable bit one turns the pin driver on; zero leaves it an input.
// RQ5 - Alternate select overrides the drive-enable bit for that pin.
// RQ6 - Alternate select connects the pin to its on-chip alternate function.
// RQ7 - Port B and C output latches clear to zero at reset.
`default_nettype none
module tpg_gpio (
  // Clock and reset.
  input  wire logic                                        aclk,
  input  wire logic                                        aresetn,
  // Write address channel.
  input  wire logic [tpg_pkg::ADDR_W-1:0]                  s_axi_awaddr,
  input  wire logic                                        s_axi_awvalid,
  output logic                                             s_axi_awready,
  // Write data channel.
  input  wire logic [31:0]                                 s_axi_wdata,
  input  wire logic [3:0]                                  s_axi_wstrb,
  input  wire logic                                        s_axi_wvalid,
  output logic                                             s_axi_wready,
  // Write response channel.
  output logic [1:0]                                       s_axi_bresp,
  output logic                                             s_axi_bvalid,
  input  wire logic                                        s_axi_bready,
  // Read address channel.
  input  wire logic [tpg_pkg::ADDR_W-1:0]                  s_axi_araddr,
  input  wire logic                                        s_axi_arvalid,
  output logic                                             s_axi_arready,
  // Read data channel.
  output logic [31:0]                                      s_axi_rdata,
  output logic [1:0]                                       s_axi_rresp,
  output logic                                             s_axi_rvalid,
  input  wire logic                                        s_axi_rready,
  // Port pins.
  input  wire logic [tpg_pkg::NPORT-1:0][tpg_pkg::PW-1:0]  pin_i,
  output var tpg_pkg::tpg_drive_type [tpg_pkg::NPORT-1:0]  pin_drv,
  // Alternate on-chip functions.
  input  wire tpg_pkg::tpg_drive_type [tpg_pkg::NPORT-1:0] alt_drv,
  output logic [tpg_pkg::NPORT-1:0][tpg_pkg::PW-1:0]       alt_i
);
  import tpg_pkg::*;

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  logic                           aw_hold_q, aw_hold_d;
  logic [ADDR_W-1:0]              awaddr_q, awaddr_d;
  logic                           w_hold_q, w_hold_d;
  logic [PW-1:0]                  wdata_q, wdata_d;
  logic                           wlane_q, wlane_d;
  logic                           bvalid_q, bvalid_d;
  logic [1:0]                     bresp_q, bresp_d;
  logic                           rvalid_q, rvalid_d;
  logic [1:0]                     rresp_q, rresp_d;
  logic [31:0]                    rdata_q, rdata_d;
  logic                           wr_en;
  logic                           ar_fire;
  tpg_dec_type                    wr_dec;
  tpg_dec_type                    ar_dec;
  logic [NPORT-1:0][PW-1:0]       out_q, out_d;
  logic [NPORT-1:0][PW-1:0]       oe_q, oe_d;
  logic [NPORT-1:0][PW-1:0]       sel_q, sel_d;
  logic [NPORT-1:0][PW-1:0]       samp;
  tpg_drive_type [NPORT-1:0]      drv_d;

  // ----------------------------------------------------------------
  // Bus handshakes and decode.
  // ----------------------------------------------------------------

  // Each write phase is held until its partner arrives.
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = !w_hold_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;
  assign wr_dec        = tpg_decode(awaddr_q);
  assign ar_dec        = tpg_decode(s_axi_araddr);

  // ----------------------------------------------------------------
  // Write channel.
  // ----------------------------------------------------------------

  // Captures address and data in either order, then commits once.
  always_comb begin
    aw_hold_d = aw_hold_q;
    awaddr_d  = awaddr_q;
    w_hold_d  = w_hold_q;
    wdata_d   = wdata_q;
    wlane_d   = wlane_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    wr_en     = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_d = 1'b1;
      wdata_d  = s_axi_wdata[PW-1:0];
      wlane_d  = s_axi_wstrb[0];
    end
    if (aw_hold_q && w_hold_q) begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_dec.hit ? RESP_OKAY : RESP_SLVERR;
      wr_en     = wr_dec.hit && wlane_q;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  // Registers the write channel state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      awaddr_q  <= '0;
      w_hold_q  <= 1'b0;
      wdata_q   <= '0;
      wlane_q   <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      aw_hold_q <= aw_hold_d;
      awaddr_q  <= awaddr_d;
      w_hold_q  <= w_hold_d;
      wdata_q   <= wdata_d;
      wlane_q   <= wlane_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  // ----------------------------------------------------------------
  // Port registers.
  // ----------------------------------------------------------------

  // Latch writes land whatever the drive enable says; sample is read-only.
  always_comb begin
    out_d = out_q;
    oe_d  = oe_q;
    sel_d = sel_q;
    if (wr_en) begin
      unique case (wr_dec.kind)
        KIND_OUT: out_d[wr_dec.port] = wdata_q; // RQ2
        KIND_OE:  oe_d[wr_dec.port]  = wdata_q;
        KIND_SEL: sel_d[wr_dec.port] = wdata_q;
        KIND_PIN: out_d = out_q;
      endcase
    end
  end

  // Registers the port state; all latches clear at reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= {NPORT{OUT_RST}}; // RQ7
      oe_q  <= {NPORT{OE_RST}};
      sel_q <= {NPORT{SEL_RST}};
    end else begin
      out_q <= out_d;
      oe_q  <= oe_d;
      sel_q <= sel_d;
    end
  end

  // ----------------------------------------------------------------
  // Read channel.
  // ----------------------------------------------------------------

  // Returns the addressed register in the low byte.
  always_comb begin
    rvalid_d = rvalid_q;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    if (ar_fire) begin
      rvalid_d = 1'b1;
      rresp_d  = ar_dec.hit ? RESP_OKAY : RESP_SLVERR;
      rdata_d  = 32'h0000_0000;
      if (ar_dec.hit) begin
        unique case (ar_dec.kind)
          KIND_OUT: rdata_d[PW-1:0] = out_q[ar_dec.port];
          KIND_PIN: rdata_d[PW-1:0] = samp[ar_dec.port]; // RQ3
          KIND_OE:  rdata_d[PW-1:0] = oe_q[ar_dec.port];
          KIND_SEL: rdata_d[PW-1:0] = sel_q[ar_dec.port];
        endcase
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // Registers the read channel state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else begin
      rvalid_q <= rvalid_d;
      rresp_q  <= rresp_d;
      rdata_q  <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin sampling and drive.
  // ----------------------------------------------------------------

  // Pins settle through two flops before reads or alternate inputs.
  tpg_sync #(
    .W (NPORT * PW)
  ) tpg_sync_i (
    .clk   (aclk),
    .rst_n (aresetn),
    .d     (pin_i),
    .q     (samp)
  );

  // Alternate functions see the same settled levels as software.
  assign alt_i = samp; // RQ3

  // Per pin, the select bit picks alternate or latch drive.
  generate
    for (genvar p = 0; p < NPORT; p++) begin : g_port
      always_comb begin
        drv_d[p].o  = (sel_q[p] & alt_drv[p].o) | (~sel_q[p] & out_q[p]); // RQ1 RQ6
        drv_d[p].oe = (sel_q[p] & alt_drv[p].oe) | (~sel_q[p] & oe_q[p]); // RQ4 RQ5
      end
    end
  endgenerate

  // Registers the pin drivers; pins float during reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_drv <= '0;
    end else begin
      pin_drv <= drv_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  generate
    for (genvar p = 0; p < NPORT; p++) begin : g_chk
      property p_latch_drive;
        ((pin_drv[p].o ^ $past(out_q[p])) & $past(oe_q[p] & ~sel_q[p])) == 8'h00;
      endproperty
      a_latch_drive: assert property (p_latch_drive) // RQ1
        else $error("Pin data differs from its latch.");

      property p_hidden_store;
        (wr_en && wr_dec.kind == KIND_OUT && wr_dec.port == 2'(p) && oe_q[p] == 8'h00
          && sel_q[p] == 8'h00) |=> (out_q[p] == $past(wdata_q)) ##1 (pin_drv[p].oe == 8'h00);
      endproperty
      a_hidden_store: assert property (p_hidden_store) // RQ2
        else $error("Latch write lost or pin driven.");

      property p_enable_drive;
        ((pin_drv[p].oe ^ $past(oe_q[p])) & ~$past(sel_q[p])) == 8'h00;
      endproperty
      a_enable_drive: assert property (p_enable_drive) // RQ4
        else $error("Driver enable differs from its register.");

      property p_alt_enable;
        ((pin_drv[p].oe ^ $past(alt_drv[p].oe)) & $past(sel_q[p])) == 8'h00;
      endproperty
      a_alt_enable: assert property (p_alt_enable) // RQ5
        else $error("Alternate pin follows the enable register.");

      property p_alt_data;
        ((pin_drv[p].o ^ $past(alt_drv[p].o)) & $past(sel_q[p])) == 8'h00;
      endproperty
      a_alt_data: assert property (p_alt_data) // RQ6
        else $error("Alternate pin data not routed.");
    end
  endgenerate

  property p_pin_read;
    (ar_fire && ar_dec.hit && ar_dec.kind == KIND_PIN && ar_dec.port == 2'h0)
      |=> (s_axi_rdata[PW-1:0] == $past(pin_i[0], 3));
  endproperty
  a_pin_read: assert property (p_pin_read) // RQ3
    else $error("Pin sample read is not the pin level.");

  property p_reset_clear;
    $rose(aresetn) |-> (out_q[1] == 8'h00 && out_q[2] == 8'h00);
  endproperty
  a_reset_clear: assert property (p_reset_clear) // RQ7
    else $error("Port B or C latch not cleared.");

  property p_bresp_hold;
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid;
  endproperty
  a_bresp_hold: assert property (p_bresp_hold)
    else $error("Write response dropped early.");

endmodule : tpg_gpio
`default_nettype wire

/* tpg_board.sv */
`default_nettype none
module tpg_board (
  // Device drive.
  input  wire tpg_pkg::tpg_drive_type [tpg_pkg::NPORT-1:0] pin_drv,
  // Board drive per pin.
  input  wire logic [tpg_pkg::NPORT-1:0][tpg_pkg::PW-1:0]  brd_val,
  input  wire logic [tpg_pkg::NPORT-1:0][tpg_pkg::PW-1:0]  brd_oe,
  // Resolved pin levels.
  output logic [tpg_pkg::NPORT-1:0][tpg_pkg::PW-1:0]       pin_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  import tpg_pkg::*;

  // A pin follows the device when it drives, else the board, else the pull-up.
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      pin_lvl[p] = (pin_drv[p].oe & pin_drv[p].o) | (~pin_drv[p].oe & ~brd_oe[p])
                 | (~pin_drv[p].oe & brd_oe[p] & brd_val[p]);
    end
  end
endmodule : tpg_board
`default_nettype wire

/* three_port_gpio_tb.sv */
`default_nettype none
module three_port_gpio_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tpg_pkg::*;

  // ----------------------------------------------------------------
  // Signals.
  // ----------------------------------------------------------------
  logic                          aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic                          s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic                          s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [ADDR_W-1:0]             s_axi_awaddr, s_axi_araddr;
  logic [31:0]                   s_axi_wdata, s_axi_rdata;
  logic [3:0]                    s_axi_wstrb;
  logic [1:0]                    s_axi_bresp, s_axi_rresp;
  logic [NPORT-1:0][PW-1:0]      pins, alt_i, brd_val, brd_oe;
  tpg_drive_type [NPORT-1:0]     pin_drv, alt_drv;
  int                            fails, checks_done, cyc;
  logic [IDX_W-1:0] out_idx[3] = '{IDX_OUT_A, IDX_OUT_B, IDX_OUT_C};
  logic [IDX_W-1:0] oe_idx[3]  = '{IDX_OE_A, IDX_OE_B, IDX_OE_C};
  logic [IDX_W-1:0] sel_idx[3] = '{IDX_SEL_A, IDX_SEL_B, IDX_SEL_C};
  logic [IDX_W-1:0] pin_idx[3] = '{IDX_PIN_A, IDX_PIN_B, IDX_PIN_C};
  logic [PW-1:0]    pat[3]     = '{8'h5a, 8'h96, 8'h69};

  tpg_gpio tpg_gpio_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pin_i(pins), .pin_drv(pin_drv), .alt_drv(alt_drv), .alt_i(alt_i));
  tpg_board tpg_board_i (.pin_drv(pin_drv), .brd_val(brd_val), .brd_oe(brd_oe), .pin_lvl(pins));

  // ----------------------------------------------------------------
  // Clock, watchdog and report.
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // A hang ends the run as a failure.
  initial begin
    cyc = 0;
    forever begin
      @(posedge aclk);
      cyc++;
      if (cyc == 5000) begin
        fails++;
        tally_and_finish();
      end
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check_val

  task automatic check_rsp(input string name, input logic [1:0] exp, input logic [1:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check_rsp

  // ----------------------------------------------------------------
  // Bus tasks; readies are sampled on the falling edge, stable up to the rising one.
  // ----------------------------------------------------------------
  task automatic axi_write(input logic [IDX_W-1:0] idx, input logic [7:0] d, input logic [3:0] strb,
                           input logic [1:0] rsp);
    logic aw_d, w_d, b_d, aw_s, w_s, b_s;
    logic [1:0] r_s;
    aw_d = 1'b0;
    w_d = 1'b0;
    b_d = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_wdata   <= {24'h00_0000, d};
    s_axi_wstrb   <= strb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!b_d) begin
      @(negedge aclk);
      aw_s = s_axi_awready;
      w_s = s_axi_wready;
      b_s = s_axi_bvalid;
      r_s = s_axi_bresp;
      @(posedge aclk);
      if (!aw_d && aw_s) begin
        aw_d = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_d && w_s) begin
        w_d = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (b_s) begin
        b_d = 1'b1;
        s_axi_bready <= 1'b0;
      end
    end
    check_rsp("bresp", rsp, r_s);
  endtask : axi_write

  task automatic axi_read(input logic [IDX_W-1:0] idx, input logic [7:0] exp, input logic [1:0] rsp);
    logic ar_d, r_d, ar_s, rv_s;
    logic [31:0] d_s;
    logic [1:0] r_s;
    ar_d = 1'b0;
    r_d = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!r_d) begin
      @(negedge aclk);
      ar_s = s_axi_arready;
      rv_s = s_axi_rvalid;
      d_s = s_axi_rdata;
      r_s = s_axi_rresp;
      @(posedge aclk);
      if (!ar_d && ar_s) begin
        ar_d = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
      if (rv_s) begin
        r_d = 1'b1;
        s_axi_rready <= 1'b0;
      end
    end
    check_val("rdata", {24'h00_0000, exp}, d_s);
    check_rsp("rresp", rsp, r_s);
  endtask : axi_read

  // Lets drive, synchroniser and alternate outputs settle.
  task automatic settle();
    repeat (4) @(posedge aclk);
    @(negedge aclk);
  endtask : settle

  // ----------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------
  initial begin
    fails = 0;
    checks_done = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = '0;
    alt_drv = '0;
    brd_val = 24'h00_0030;
    brd_oe = 24'h00_00f0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int p = 0; p < 3; p++) begin
      axi_read(out_idx[p], OUT_RST, RESP_OKAY);
      axi_read(oe_idx[p], OE_RST, RESP_OKAY);
      axi_read(sel_idx[p], SEL_RST, RESP_OKAY);
      axi_read(pin_idx[p], (p == 0) ? 8'h3f : 8'hff, RESP_OKAY);
    end
    axi_write(IDX_OUT_A, pat[0], 4'h1, RESP_OKAY);
    settle();
    check_val("pins_a", 32'h0000_003f, pins[0]);
    axi_read(IDX_OUT_A, pat[0], RESP_OKAY);
    axi_write(IDX_OE_A, 8'h0f, 4'h1, RESP_OKAY);
    settle();
    check_val("pins_a", 32'h0000_003a, pins[0]);
    axi_read(IDX_PIN_A, 8'h3a, RESP_OKAY);
    alt_drv[0] <= '{o: 8'h00, oe: 8'h02};
    axi_write(IDX_SEL_A, 8'h03, 4'h1, RESP_OKAY);
    settle();
    check_val("pins_a", 32'h0000_0039, pins[0]);
    check_val("alt_a", 32'h0000_0039, alt_i[0]);
    axi_read(IDX_PIN_A, 8'h39, RESP_OKAY);
    axi_read(IDX_OE_A, 8'h0f, RESP_OKAY);
    for (int p = 1; p < 3; p++) begin
      axi_write(out_idx[p], pat[p], 4'h1, RESP_OKAY);
      axi_write(oe_idx[p], 8'hff, 4'h1, RESP_OKAY);
      settle();
      check_val("pins", {24'h00_0000, pat[p]}, pins[p]);
      axi_read(pin_idx[p], pat[p], RESP_OKAY);
      axi_write(oe_idx[p], 8'h00, 4'h1, RESP_OKAY);
      settle();
      check_val("pins", 32'h0000_00ff, pins[p]);
      axi_read(out_idx[p], pat[p], RESP_OKAY);
    end
    axi_write(15'h7f9f, 8'h11, 4'h1, RESP_SLVERR);
    axi_read(15'h7f9f, 8'h00, RESP_SLVERR);
    axi_write(IDX_PIN_B, 8'h00, 4'h1, RESP_OKAY);
    axi_read(IDX_PIN_B, 8'hff, RESP_OKAY);
    axi_write(IDX_OUT_B, 8'h00, 4'h0, RESP_OKAY);
    axi_read(IDX_OUT_B, pat[1], RESP_OKAY);
    axi_read(IDX_OUT_A, pat[0], RESP_OKAY);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(IDX_OUT_B, OUT_RST, RESP_OKAY);
    axi_read(IDX_OUT_C, OUT_RST, RESP_OKAY);
    settle();
    check_val("pins_a", 32'h0000_003f, pins[0]);
    tally_and_finish();
  end
endmodule : three_port_gpio_tb
`default_nettype wire
